// ---- design/dbgtr_pkg.sv ----
// Summary of operation
// - Tag request travels with the fetched opcode; CPU runs background opcode instead.
// - Force request lets current instruction finish, then CPU enters background.
// - Tag qualify select routes each comparator through its own opcode tracker.
// - Four-bit trigger mode field picks one of nine trigger modes.
// - Trace start select: begin on trigger, or circular store until trigger.
// - Writing start bit arms run, clears both match flags and valid count.
// - Begin-trace run ends on FIFO full; end-trace run ends on trigger.
// - Writing start or module enable to zero stops the run at once.
// - Event-only modes store 8-bit data low, always begin-type traces.
// - Optional read/write qualification per comparator against chosen value.
// - Breakpoint enable turns trigger into CPU request; kind bit picks tag/force.
// - A-only triggers on A match; A-or-B on either match.
// - A-then-B triggers on B match any time after an A match.
// - Full mode: address on A, data on B low byte, same cycle.
// - Full-not mode: address on A, data differs from B low byte.
// - Tag breakpoints in full modes ignore data, use A address alone.
// - Event-only B stores bus data on each B match until full.
// - A-then-event-only-B stores data on B matches only after A matched.
// - Inside range A..B inclusive; outside range below A or above B.
// - Without background permit, breakpoints become software interrupts.
// - Background permit ignores writes while active; clock select always writable.
// - The four background status bits are read-only.
// - Trace FIFO holds eight entries of address or data.
// - Comparators are blinded during serial background controller accesses.
package dbgtr_pkg;
	localparam int          FIFO_DEPTH  = 8;
	localparam logic [3:0]  FIFO_FULL   = 4'h8;
	localparam int          QDEPTH      = 4;
	// Trigger mode codes
	localparam logic [3:0]  M_A_ONLY    = 4'h0;
	localparam logic [3:0]  M_A_OR_B    = 4'h1;
	localparam logic [3:0]  M_A_THEN_B  = 4'h2;
	localparam logic [3:0]  M_EV_B      = 4'h3;
	localparam logic [3:0]  M_A_THEN_EV = 4'h4;
	localparam logic [3:0]  M_FULL      = 4'h5;
	localparam logic [3:0]  M_FULL_NOT  = 4'h6;
	localparam logic [3:0]  M_INSIDE    = 4'h7;
	localparam logic [3:0]  M_OUTSIDE   = 4'h8;
	// Register selects
	localparam logic [2:0]  SEL_CTRL    = 3'h0;
	localparam logic [2:0]  SEL_TRIG    = 3'h1;
	localparam logic [2:0]  SEL_CMPA    = 3'h2;
	localparam logic [2:0]  SEL_CMPB    = 3'h3;
	localparam logic [2:0]  SEL_STAT    = 3'h4;
	localparam logic [2:0]  SEL_BSCR    = 3'h5;
	localparam logic [2:0]  SEL_BKPT    = 3'h6;
	// Control register fields
	localparam int          C_EN        = 7;
	localparam int          C_ARM       = 6;
	localparam int          C_TAG       = 5;
	localparam int          C_BREAKPOINT_ENABLE     = 4;
	localparam int          C_CMP_FIRST_RW_QUALIFY_EN     = 3;
	localparam int          C_RWA       = 2;
	localparam int          C_CMP_SECOND_RW_QUALIFY_EN     = 1;
	localparam int          C_RWB       = 0;
	// Trigger register fields
	localparam int          T_QSEL      = 7;
	localparam int          T_BEGIN     = 6;
	// Background status/control fields
	localparam int          B_PERMIT    = 7;
	localparam int          B_BKPTEN    = 5;
	localparam int          B_FTS       = 4;
	localparam int          B_LINK_CLOCK_SELECT     = 3;
endpackage

// ---- design/dbgtr_tracker.sv ----
module dbgtr_tracker
	import dbgtr_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Instruction queue events
	input  wire logic i_fetch,
	input  wire logic i_match,
	input  wire logic i_exec,
	input  wire logic i_flush,
	// Executed tagged opcode
	output logic      o_hit
);
	typedef struct packed {
		logic [QDEPTH-1:0] tags;
		logic [2:0]        cnt;
		logic              hit;
	} dbgtr_trk_t;

	dbgtr_trk_t q;
	dbgtr_trk_t n;

	// Mirrors queue occupancy; a flush drops fetched but unexecuted tags
	always_comb
	begin
		n = q;
		n.hit = 1'b0;
		if (i_flush)
		begin
			n.tags = '0;
			n.cnt = 3'h0;
		end
		else
		begin
			if (i_exec && q.cnt != 3'h0)
			begin
				n.hit = q.tags[0];
				n.tags = q.tags >> 1;
				n.cnt = q.cnt - 3'h1;
			end
			if (i_fetch && n.cnt < 3'(QDEPTH))
			begin
				n.tags[n.cnt[1:0]] = i_match;
				n.cnt = n.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			q <= '0;
		else
			q <= n;
	end

	assign o_hit = q.hit;

	hit_cause_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) o_hit |-> $past(i_exec))
		else $error("tracker hit without execute");
endmodule

// ---- design/dbgtr_fifo_mem.sv ----
module dbgtr_fifo_mem
	import dbgtr_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Write port
	input  wire logic        i_we,
	input  wire logic [2:0]  i_waddr,
	input  wire logic [15:0] i_wdata,
	// Read port
	input  wire logic [2:0]  i_raddr,
	output logic [15:0]      o_rdata
);
	typedef struct packed {
		logic [FIFO_DEPTH-1:0][15:0] mem;
		logic [15:0]                 rd;
	} dbgtr_mem_t;

	dbgtr_mem_t q;
	dbgtr_mem_t n;

	always_comb
	begin
		n = q;
		if (i_we)
			n.mem[i_waddr] = i_wdata;
		n.rd = q.mem[i_raddr];
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			q <= '0;
		else
			q <= n;
	end

	assign o_rdata = q.rd;
endmodule

// ---- design/dbgtr_top.sv ----
module dbgtr_top
	import dbgtr_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// CPU bus
	input  wire logic        i_bus_valid,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_bus_rdata,
	input  wire logic [7:0]  i_bus_wdata,
	input  wire logic        i_rw,
	input  wire logic        i_bdc_access,
	// Instruction queue
	input  wire logic        i_opfetch,
	input  wire logic        i_exec,
	input  wire logic        i_flush,
	input  wire logic        i_cof_valid,
	input  wire logic [15:0] i_cof_addr,
	// Background controller status
	input  wire logic        i_bdm_active,
	input  wire logic        i_ws,
	input  wire logic        i_wsf,
	input  wire logic        i_dvf,
	// Register access
	input  wire logic        i_reg_wr,
	input  wire logic [2:0]  i_reg_sel,
	input  wire logic [15:0] i_reg_wdata,
	output logic [15:0]      o_reg_rdata,
	// FIFO readout
	input  wire logic [2:0]  i_fifo_raddr,
	output logic [15:0]      o_fifo_rdata,
	// CPU break requests and link clock select
	output logic             o_tag_req,
	output logic             o_force_req,
	output logic             o_use_swi,
	output logic             o_link_clock_select
);
	typedef struct packed {
		logic        en;
		logic        tagk;
		logic        breakpoint_enable;
		logic        cmp_first_rw_qualify_en;
		logic        cmp_first_rw_value;
		logic        cmp_second_rw_qualify_en;
		logic        cmp_second_rw_value;
		logic        qsel;
		logic        beg;
		logic [3:0]  mode;
		logic [15:0] cmpa;
		logic [15:0] cmpb;
		logic        armed;
		logic        af;
		logic        bf;
		logic        started;
		logic [3:0]  cnt;
		logic [2:0]  ptr;
		logic        force_q;
		logic        permit;
		logic        bkpten;
		logic        fts;
		logic        link_clock_select;
		logic [15:0] bkpt;
		logic [15:0] rdata;
	} dbgtr_state_t;

	dbgtr_state_t q;
	dbgtr_state_t n;

	function automatic logic rw_ok(input logic en, input logic val, input logic rw);
		rw_ok = !en || (rw == val);
	endfunction

	function automatic logic trig_of(input logic [3:0] mode, input logic ma, input logic mb,
		input logic dok, input logic af);
		unique case (mode)
			M_A_ONLY:    trig_of = ma;
			M_A_OR_B:    trig_of = ma | mb;
			M_A_THEN_B:  trig_of = mb & af;
			M_EV_B:      trig_of = mb;
			M_A_THEN_EV: trig_of = mb & af;
			M_FULL:      trig_of = ma & dok;
			M_FULL_NOT:  trig_of = ma & dok;
			M_INSIDE:    trig_of = ma;
			M_OUTSIDE:   trig_of = ma;
			default:     trig_of = 1'b0;
		endcase
	endfunction

	logic        live;
	logic        rng_in;
	logic        ma;
	logic        mb;
	logic        ta;
	logic        tb;
	logic        fa;
	logic        fb;
	logic [7:0]  dsel;
	logic        dok;
	logic        trig;
	logic        evonly;
	logic        endtype;
	logic        wr_en;
	logic [15:0] fifo_wdata;

	// Tag-qualified matches, one tracker per comparator
	dbgtr_tracker u_trk_a (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_fetch  (i_opfetch),
		.i_match  (ma),
		.i_exec   (i_exec),
		.i_flush  (i_flush),
		.o_hit    (ta)
	);

	dbgtr_tracker u_trk_b (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_fetch  (i_opfetch),
		.i_match  (mb),
		.i_exec   (i_exec),
		.i_flush  (i_flush),
		.o_hit    (tb)
	);

	dbgtr_fifo_mem u_fifo (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_we     (wr_en),
		.i_waddr  (q.ptr),
		.i_wdata  (fifo_wdata),
		.i_raddr  (i_fifo_raddr),
		.o_rdata  (o_fifo_rdata)
	);

	always_comb
	begin
		live = i_bus_valid && !i_bdc_access;
		rng_in = (i_addr >= q.cmpa) && (i_addr <= q.cmpb);
		dsel = (q.cmp_first_rw_qualify_en && !q.cmp_first_rw_value) ? i_bus_wdata : i_bus_rdata;
		dok = (dsel == q.cmpb[7:0]) ^ (q.mode == M_FULL_NOT);
		if (q.mode == M_INSIDE)
			ma = live && rng_in;
		else if (q.mode == M_OUTSIDE)
			ma = live && !rng_in;
		else
			ma = live && (i_addr == q.cmpa);
		ma = ma && rw_ok(q.cmp_first_rw_qualify_en, q.cmp_first_rw_value, i_rw);
		mb = live && (i_addr == q.cmpb) && rw_ok(q.cmp_second_rw_qualify_en, q.cmp_second_rw_value, i_rw);
		// Data is never tracked, so tag-qualified full modes check address only
		fa = q.qsel ? ta : ma;
		fb = q.qsel ? tb : mb;
		trig = q.armed && trig_of(q.mode, fa, fb, q.qsel | dok, q.af);
		evonly = (q.mode == M_EV_B) || (q.mode == M_A_THEN_EV);
		endtype = !evonly && !q.beg;
		if (evonly)
			wr_en = trig;
		else
			wr_en = q.armed && i_cof_valid && (endtype || q.started);
		fifo_wdata = evonly ? {8'h00, dsel} : i_cof_addr;
	end

	// Tag rides with the opcode fetch; data match ignored for tags
	assign o_tag_req = q.en && q.breakpoint_enable && q.tagk && q.armed && i_opfetch
		&& trig_of(q.mode, ma, mb, 1'b1, q.af);
	assign o_force_req = q.force_q;
	assign o_use_swi = !q.permit;
	assign o_link_clock_select = q.link_clock_select;
	assign o_reg_rdata = q.rdata;

	always_comb
	begin
		n = q;
		n.force_q = q.en && q.breakpoint_enable && !q.tagk && trig;
		if (q.armed && fa)
			n.af = 1'b1;
		if (q.armed && fb)
			n.bf = 1'b1;
		if (trig && !endtype)
			n.started = 1'b1;
		if (wr_en)
		begin
			n.ptr = q.ptr + 3'h1;
			// End-trace wraps the pointer and keeps count pinned at full
			n.cnt = (q.cnt == FIFO_FULL) ? FIFO_FULL : q.cnt + 4'h1;
		end
		if (!endtype && n.cnt == FIFO_FULL)
			n.armed = 1'b0;
		if (endtype && trig)
			n.armed = 1'b0;
		if (i_reg_wr)
		begin
			unique case (i_reg_sel)
				SEL_CTRL:
				begin
					n.en = i_reg_wdata[C_EN];
					n.tagk = i_reg_wdata[C_TAG];
					n.breakpoint_enable = i_reg_wdata[C_BREAKPOINT_ENABLE];
					n.cmp_first_rw_qualify_en = i_reg_wdata[C_CMP_FIRST_RW_QUALIFY_EN];
					n.cmp_first_rw_value = i_reg_wdata[C_RWA];
					n.cmp_second_rw_qualify_en = i_reg_wdata[C_CMP_SECOND_RW_QUALIFY_EN];
					n.cmp_second_rw_value = i_reg_wdata[C_RWB];
					n.armed = i_reg_wdata[C_ARM] && i_reg_wdata[C_EN];
					if (n.armed)
					begin
						n.af = 1'b0;
						n.bf = 1'b0;
						n.cnt = 4'h0;
						n.ptr = 3'h0;
						n.started = 1'b0;
					end
				end
				SEL_TRIG:
				begin
					n.qsel = i_reg_wdata[T_QSEL];
					n.beg = i_reg_wdata[T_BEGIN];
					n.mode = i_reg_wdata[3:0];
				end
				SEL_CMPA: n.cmpa = i_reg_wdata;
				SEL_CMPB: n.cmpb = i_reg_wdata;
				SEL_BSCR:
				begin
					// Permit locked in background so it cannot forbid the mode it is in
					if (!i_bdm_active)
						n.permit = i_reg_wdata[B_PERMIT];
					n.bkpten = i_reg_wdata[B_BKPTEN];
					n.fts = i_reg_wdata[B_FTS];
					n.link_clock_select = i_reg_wdata[B_LINK_CLOCK_SELECT];
				end
				SEL_BKPT: n.bkpt = i_reg_wdata;
				default: n.bkpt = n.bkpt;
			endcase
		end
		if (!n.en)
			n.armed = 1'b0;
		unique case (i_reg_sel)
			SEL_CTRL:
				n.rdata = {8'h00, q.en, q.armed, q.tagk, q.breakpoint_enable, q.cmp_first_rw_qualify_en, q.cmp_first_rw_value, q.cmp_second_rw_qualify_en, q.cmp_second_rw_value};
			SEL_TRIG: n.rdata = {8'h00, q.qsel, q.beg, 2'b00, q.mode};
			SEL_CMPA: n.rdata = q.cmpa;
			SEL_CMPB: n.rdata = q.cmpb;
			SEL_STAT: n.rdata = {8'h00, q.af, q.bf, q.armed, 1'b0, q.cnt};
			SEL_BSCR:
				n.rdata = {8'h00, q.permit, i_bdm_active, q.bkpten, q.fts, q.link_clock_select, i_ws, i_wsf, i_dvf};
			SEL_BKPT: n.rdata = q.bkpt;
			default:  n.rdata = 16'h0000;
		endcase
	end

	// Reset: disarmed, breakpoint enable clear
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			q <= '0;
		else
			q <= n;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	arm_start_a: assert property (i_reg_wr && i_reg_sel == SEL_CTRL && i_reg_wdata[C_ARM] && i_reg_wdata[C_EN]
		|=> q.armed && !q.af && !q.bf && q.cnt == 4'h0)
		else $error("arm write did not start run");
	run_stop_a: assert property (i_reg_wr && i_reg_sel == SEL_CTRL && !(i_reg_wdata[C_ARM] && i_reg_wdata[C_EN])
		|=> !q.armed)
		else $error("stop write left run armed");
	begin_full_a: assert property (q.armed && !endtype |-> q.cnt < FIFO_FULL)
		else $error("begin-trace run armed with full FIFO");
	end_trig_a: assert property (q.armed && endtype && trig && !i_reg_wr |=> !q.armed)
		else $error("end-trace run survived trigger");
	bdc_blind_a: assert property (i_bdc_access |-> !o_tag_req ##1 !o_force_req)
		else $error("request during background access");
	permit_lock_a: assert property (i_bdm_active |=> q.permit == $past(q.permit))
		else $error("permit changed in background");
	force_cause_a: assert property (o_force_req |-> $past(q.breakpoint_enable && !q.tagk && q.armed))
		else $error("force request without enable");
	then_order_a: assert property (q.armed && q.mode == M_A_THEN_B && !q.qsel && mb && !q.af |-> !trig)
		else $error("B trigger before A match");
	quiet_idle_a: assert property (!q.armed |-> !o_tag_req ##1 !o_force_req)
		else $error("request while disarmed");
	swi_path_a: assert property (o_force_req && !q.permit |-> o_use_swi)
		else $error("break without permit not routed to swi");
	tag_addr_only_a: assert property (q.en && q.breakpoint_enable && q.tagk && q.armed && i_opfetch && ma
		&& (q.mode == M_FULL || q.mode == M_FULL_NOT) |-> o_tag_req)
		else $error("full mode tag request waited on data");
	ev_capture_a: assert property (q.armed && !q.qsel && q.mode == M_EV_B && mb |-> wr_en)
		else $error("event B match not stored");
	ev_gate_a: assert property (q.mode == M_A_THEN_EV && !q.af |-> !wr_en)
		else $error("event store before A match");
	range_in_a: assert property (trig && !q.qsel && q.mode == M_INSIDE
		|-> i_addr >= q.cmpa && i_addr <= q.cmpb)
		else $error("inside range trigger out of range");
	range_out_a: assert property (q.armed && !q.qsel && !q.cmp_first_rw_qualify_en && q.mode == M_OUTSIDE && live
		&& i_addr > q.cmpb |-> trig)
		else $error("address above range did not trigger");
	either_match_a: assert property (q.armed && !q.qsel && q.mode == M_A_OR_B && mb |-> trig)
		else $error("B match missed in either mode");
	event_full_a: assert property (q.armed && evonly && wr_en && q.cnt == FIFO_FULL - 4'h1
		&& !i_reg_wr |=> !q.armed)
		else $error("event run armed after FIFO filled");
	link_clock_select_write_a: assert property (i_reg_wr && i_reg_sel == SEL_BSCR
		|=> q.link_clock_select == $past(i_reg_wdata[B_LINK_CLOCK_SELECT]))
		else $error("clock select write lost");
	cmp_blind_a: assert property (i_bdc_access |-> !ma && !mb)
		else $error("comparator matched during background access");
	force_follow_a: assert property (q.en && q.breakpoint_enable && !q.tagk && trig |=> o_force_req)
		else $error("trigger gave no force request");
endmodule

// ---- test/dbgtr_cpu.sv ----
module dbgtr_cpu
	import dbgtr_pkg::*;
(
	// Clock
	input  wire logic i_clk,
	// Break requests
	input  wire logic i_tag_req,
	input  wire logic i_force_req,
	input  wire logic i_use_swi,
	// Queue events and background state
	output logic      o_fetch,
	output logic      o_exec,
	output logic      o_flush,
	output logic      o_bdm
);
	timeunit 1ns;
	timeprecision 1ps;
	bit q[$];
	bit fpend = 0;
	int swi_cnt = 0;
	initial
	begin
		{o_fetch, o_exec, o_flush} = 3'h0;
		o_bdm = 1'b0;
	end
	task automatic drive(input logic [2:0] op);
		{o_fetch, o_exec, o_flush} = op;
	endtask
	task automatic resume;
		o_bdm = 1'b0;
		fpend = 0;
	endtask
	// Sampled before the debug block's flops update, so pulses are seen whole
	always @(posedge i_clk)
	begin
		if (o_flush)
			q.delete();
		if (o_fetch)
			q.push_back(i_tag_req);
		if (i_force_req)
			fpend = 1;
		if (o_exec)
		begin
			// Force waits for the instruction boundary
			if ((q.size() > 0 && q.pop_front()) || fpend)
			begin
				fpend = 0;
				if (i_use_swi)
					swi_cnt++;
				else
					o_bdm <= 1'b1;
			end
		end
	end
endmodule

// ---- test/dbgtr_tb.sv ----
module dbgtr_tb
	import dbgtr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int k; logic [15:0] m; logic [15:0] v;} dbgtr_note_t;
	logic clk, rst_n, valid, rw, bdc, ws, wait_stop_failure_status, fourth_status_bit, wr, tag, frc, software_interrupt_opcode, lcs, fetch, exec, flush, bdm, cof;
	logic [15:0] addr, wd, rdata, frd, caddr;
	logic [7:0]  rdat, wdat;
	logic [7:0]  d [9];
	logic [2:0]  sel, fra;
	int          rk, miscompares, compares, cyc_n;
	dbgtr_note_t nq[$];

	dbgtr_top dut_u (.i_clk(clk), .i_arst_n(rst_n), .i_bus_valid(valid), .i_addr(addr), .i_bus_rdata(rdat),
		.i_bus_wdata(wdat), .i_rw(rw), .i_bdc_access(bdc), .i_opfetch(fetch), .i_exec(exec), .i_flush(flush),
		.i_cof_valid(cof), .i_cof_addr(caddr), .i_bdm_active(bdm), .i_ws(ws), .i_wsf(wait_stop_failure_status), .i_dvf(fourth_status_bit),
		.i_reg_wr(wr), .i_reg_sel(sel), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_fifo_raddr(fra),
		.o_fifo_rdata(frd), .o_tag_req(tag), .o_force_req(frc), .o_use_swi(software_interrupt_opcode), .o_link_clock_select(lcs));
	dbgtr_cpu cpu_u (.i_clk(clk), .i_tag_req(tag), .i_force_req(frc), .i_use_swi(software_interrupt_opcode), .o_fetch(fetch),
		.o_exec(exec), .o_flush(flush), .o_bdm(bdm));

	initial
	begin
		clk = 0;
		forever
			#2.5 clk = ~clk;
	end
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic note(input int k, input logic [15:0] m, input logic [15:0] v);
		nq.push_back('{k, m, v});
	endtask
	task automatic take(input int k, input logic [15:0] v);
		dbgtr_note_t n;
		n = (nq.size() == 0) ? '{-1, 16'h0000, 16'h0000} : nq.pop_front();
		check("result kind", 16'(k), 16'(n.k));
		check("result value", v & n.m, n.v);
	endtask
	// Results are matched in order of appearance, not by fixed latency
	always @(posedge clk)
	begin
		#1;
		if (rk == 0)
			take(0, rdata);
		if (rk == 1)
			take(1, frd);
		if (frc === 1'b1)
			take(2, 16'h0000);
		if (tag === 1'b1)
			take(3, 16'h0000);
	end
	task automatic report_and_stop;
		if (nq.size() != 0)
			miscompares++;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc_n++;
		if (cyc_n == 5000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic wr_reg(input logic [2:0] s, input logic [15:0] v);
		{wr, sel, wd} = {1'b1, s, v};
		@(negedge clk);
		wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input int k, input logic [2:0] s, input logic [15:0] m, input logic [15:0] e);
		note(k, m, e);
		{sel, fra} = {s, s};
		rk = k;
		@(negedge clk);
		rk = -1;
		@(negedge clk);
	endtask
	task automatic bus(input logic [15:0] a, input logic [7:0] dt, input bit r, input bit b, input int t,
		input logic [2:0] op = 3'h0);
		if (t != 0)
			note(t, 16'h0000, 16'h0000);
		{valid, addr, rw, bdc, rdat, wdat} = {1'b1, a, r, b, dt, ~dt};
		cpu_u.drive(op);
		@(negedge clk);
	endtask
	task automatic idle(input int n);
		valid = 1'b0;
		cpu_u.drive(3'h0);
		repeat (n) @(negedge clk);
	endtask
	task automatic mode(input logic [7:0] t, input logic [7:0] c);
		wr_reg(SEL_TRIG, {8'h00, t});
		wr_reg(SEL_CTRL, {8'h00, c});
		rd(0, SEL_STAT, 16'hFFFF, 16'h0020);
	endtask
	task automatic fin;
		idle(3);
		rd(0, SEL_STAT, 16'h0020, 16'h0000);
	endtask

	initial
	begin
		void'($urandom(9356));
		{rst_n, valid, addr, rdat, wdat, rw, bdc, wr, sel, wd, fra, cof, caddr} = '0;
		{ws, wait_stop_failure_status, fourth_status_bit} = 3'($urandom);
		rk = -1;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		check("use swi", 16'(software_interrupt_opcode), 16'h0001);
		rd(0, SEL_STAT, 16'hFFFF, 16'h0000);
		rd(0, SEL_CTRL, 16'hFFFF, 16'h0000);
		rd(0, SEL_BSCR, 16'hFFFF, {13'h0000, ws, wait_stop_failure_status, fourth_status_bit});
		wr_reg(SEL_CMPA, 16'h1234);
		wr_reg(SEL_CMPB, 16'h1240);
		// End-type runs: exactly one break each
		mode({4'h0, M_A_ONLY}, 8'hDC);
		bus(16'h1234, 8'h00, 1, 1, 0);
		bus(16'h1234, 8'h00, 0, 0, 0);
		bus(16'h1240, 8'h00, 1, 0, 0);
		bus(16'h1234, 8'h00, 1, 0, 2);
		bus(16'h1234, 8'h00, 1, 0, 0);
		fin();
		mode({4'h0, M_A_OR_B}, 8'hD0);
		bus(16'h1000, 8'h00, 1, 0, 0);
		bus(16'h1240, 8'h00, 1, 0, 2);
		fin();
		mode({4'h0, M_A_THEN_B}, 8'hD0);
		bus(16'h1240, 8'h00, 1, 0, 0);
		bus(16'h1234, 8'h00, 1, 0, 0);
		bus(16'h1000, 8'h00, 1, 0, 0);
		bus(16'h1240, 8'h00, 1, 0, 2);
		fin();
		mode({4'h0, M_INSIDE}, 8'hD0);
		bus(16'h1233, 8'h00, 1, 0, 0);
		bus(16'h1241, 8'h00, 1, 0, 0);
		bus(16'h1234 + 16'($urandom_range(12)), 8'h00, 1, 0, 2);
		fin();
		mode({4'h0, M_OUTSIDE}, 8'hD0);
		bus(16'h1234, 8'h00, 1, 0, 0);
		bus(16'h1240, 8'h00, 1, 0, 0);
		bus(16'h1241, 8'h00, 1, 0, 2);
		fin();
		mode({4'h0, M_FULL}, 8'hD0);
		bus(16'h1234, 8'h41, 1, 0, 0);
		bus(16'h1240, 8'h40, 1, 0, 0);
		bus(16'h1234, 8'h40, 1, 0, 2);
		fin();
		mode({4'h0, M_FULL_NOT}, 8'hD0);
		bus(16'h1234, 8'h40, 1, 0, 0);
		bus(16'h1234, 8'h41 + 8'($urandom_range(100)), 1, 0, 2);
		fin();
		// Change-of-flow trace: begin type starts after the trigger, end type wraps until it
		mode({4'h4, M_A_ONLY}, 8'hC0);
		{cof, caddr} = {1'b1, 16'hB002};
		bus(16'h2000, 8'h00, 1, 0, 0);
		bus(16'h1234, 8'h00, 1, 0, 0);
		repeat (7)
			bus(16'h2000, 8'h00, 1, 0, 0);
		cof = 1'b0;
		idle(1);
		rd(0, SEL_STAT, 16'hFFFF, 16'h00A7);
		cof = 1'b1;
		bus(16'h2000, 8'h00, 1, 0, 0);
		cof = 1'b0;
		idle(2);
		rd(0, SEL_STAT, 16'hFFFF, 16'h0088);
		rd(1, 3'h7, 16'hFFFF, 16'hB002);
		mode({4'h0, M_A_ONLY}, 8'hC0);
		cof = 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			caddr = 16'hC000 + 16'(i);
			bus((i == 10) ? 16'h1234 : 16'h2000, 8'h00, 1, 0, 0);
		end
		cof = 1'b0;
		idle(2);
		rd(0, SEL_STAT, 16'hFFFF, 16'h0088);
		rd(1, 3'h2, 16'hFFFF, 16'hC00A);
		rd(1, 3'h3, 16'hFFFF, 16'hC003);
		for (int m = 9; m < 16; m++)
		begin
			mode({4'h0, 4'(m)}, 8'hD0);
			bus(16'h1234, 8'h40, 1, 0, 0);
			bus(16'h1240, 8'h40, 1, 0, 0);
			idle(3);
		end
		// Event store with begin bit clear: still a begin-type run
		mode({4'h0, M_EV_B}, 8'hC0);
		for (int i = 0; i < 9; i++)
		begin
			d[i] = 8'($urandom);
			bus(16'h1240, d[i], 1, 0, 0);
			bus(16'h1241, 8'h00, 1, 0, 0);
		end
		idle(2);
		rd(0, SEL_STAT, 16'hFFFF, 16'h0048);
		for (int i = 0; i < 8; i++)
			rd(1, 3'(i), 16'hFFFF, {8'h00, d[i]});
		mode({4'h0, M_A_THEN_EV}, 8'hC0);
		bus(16'h1240, 8'h11, 1, 0, 0);
		bus(16'h1234, 8'h22, 1, 0, 0);
		bus(16'h1240, 8'h33, 1, 0, 0);
		idle(1);
		wr_reg(SEL_CTRL, 16'h0080);
		bus(16'h1240, 8'h44, 1, 0, 0);
		idle(2);
		rd(0, SEL_STAT, 16'hFFFF, 16'h00C1);
		rd(1, 3'h0, 16'hFFFF, 16'h0033);
		mode({4'h0, M_EV_B}, 8'hC0);
		wr_reg(SEL_CTRL, 16'h0040);
		bus(16'h1240, 8'h55, 1, 0, 0);
		idle(2);
		rd(0, SEL_STAT, 16'h003F, 16'h0000);
		// Tag breaks in full mode ignore data; drop force requests left by runs with no execute
		cpu_u.resume();
		mode({4'h0, M_FULL}, 8'hF0);
		bus(16'h1234, 8'h41, 1, 0, 3, 3'h4);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h2);
		idle(2);
		check("swi count", 16'(cpu_u.swi_cnt), 16'h0001);
		wr_reg(SEL_BSCR, 16'h00FF);
		check("use swi", 16'(software_interrupt_opcode), 16'h0000);
		rd(0, SEL_BSCR, 16'hFFFF, {8'h00, 5'h17, ws, wait_stop_failure_status, fourth_status_bit});
		bus(16'h1234, 8'h41, 1, 0, 3, 3'h4);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h1);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h2);
		idle(2);
		check("bdm after flush", 16'(bdm), 16'h0000);
		bus(16'h1234, 8'h41, 1, 0, 3, 3'h4);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h4);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h2);
		idle(2);
		check("bdm after tag", 16'(bdm), 16'h0001);
		wr_reg(SEL_BSCR, 16'h0008);
		rd(0, SEL_BSCR, 16'hFFFF, {8'h00, 5'h19, ws, wait_stop_failure_status, fourth_status_bit});
		check("clock select", 16'(lcs), 16'h0001);
		cpu_u.resume();
		// Executed-opcode qualification
		mode({4'h8, M_A_ONLY}, 8'hD0);
		bus(16'h1234, 8'h00, 1, 0, 0, 3'h4);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h1);
		idle(3);
		bus(16'h1234, 8'h00, 1, 0, 2, 3'h4);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h2);
		idle(3);
		bus(16'h2000, 8'h00, 1, 0, 0, 3'h2);
		idle(2);
		check("bdm after force", 16'(bdm), 16'h0001);
		report_and_stop();
	end
endmodule
